// ### logic/emdb_pkg.sv
// Package: register map, field positions, reset values and limits of the DMA bus control block
package emdb_pkg;
   // ======================================================================
   // Register byte offsets
   localparam logic [7:0] CFG_ADDR     = 8'h00;
   localparam logic [7:0] BURST_ADDR   = 8'h04;
   localparam logic [7:0] STATUS_ADDR  = 8'h08;
   localparam logic [7:0] CTRL_ADDR    = 8'h0c;
   localparam logic [7:0] STATE_ADDR   = 8'h10;
   // ======================================================================
   // Configuration register fields
   localparam int CFG_WEIGHT_LSB = 0;   // Two bits, weight 1..4 coded 0..3
   localparam int CFG_RATIO_LSB  = 2;   // Two bits, ratio 1:1..4:1 coded 0..3
   localparam int CFG_TXFIRST    = 4;
   localparam int CFG_STRICT     = 5;
   localparam int CFG_ALIGN      = 6;
   localparam int CFG_FIXBURST   = 7;
   localparam int CFG_VARBURST   = 8;
   localparam int CFG_EXTDESC    = 9;
   localparam int CFG_CHAINED    = 10;
   localparam int CFG_JUMBO      = 11;
   localparam int CFG_GAP_LSB    = 16;  // Five bits, 0..31 words
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   // ======================================================================
   // Burst register fields
   localparam int BURST_RX_LSB = 0;     // Six bits each
   localparam int BURST_TX_LSB = 8;
   localparam logic [31:0] BURST_RESET = 32'h0000_0101;
   // ======================================================================
   // Status bit positions (write one to clear)
   localparam int ST_EARLY_RX = 0;
   localparam int ST_BUS_ERR  = 1;
   localparam int ST_EARLY_TX = 2;
   localparam int ST_RX_WDOG  = 3;
   localparam int ST_RX_NOBUF = 4;
   localparam int ST_RX_DONE  = 5;
   localparam int ST_TX_UFLOW = 6;
   localparam int ST_TX_JAB   = 7;
   localparam int ST_TX_NOBUF = 8;
   localparam int ST_TX_STOP  = 9;
   localparam int NUM_EVENTS  = 10;
   // ======================================================================
   // Control register bits (poll bits write one, self clearing)
   localparam int CTRL_ENABLE  = 0;     // Level: DMA enable
   localparam int CTRL_RX_POLL = 1;
   localparam int CTRL_TX_POLL = 2;
   // ======================================================================
   // Frame length limits in bytes, descriptor sizes in words
   localparam int unsigned LEN_STD   = 2048;
   localparam int unsigned LEN_JUMBO = 10240;
   localparam int DESC_BASE_WORDS     = 4;
   localparam int DESC_EXT_WORDS      = 8;
endpackage : emdb_pkg

// ### logic/emdb_wrr.sv
// Weighted round robin arbiter between receive and transmit channels
`timescale 1ns/1ps
`default_nettype none
module emdb_wrr
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       rx_req,
   input  wire logic       tx_req,
   input  wire logic       done,
   input  wire logic [1:0] ratio,
   input  wire logic       tx_first,
   input  wire logic       strict,
   output logic            rx_gnt,
   output logic            tx_gnt
);
   // ======================================================================
   // Favoured channel gets ratio+1 grants per grant of the other one
   // Three bits so the 4:1 count can reach four without wrapping to zero
   logic [2:0] credit_q;
   logic [2:0] credit_d;
   logic       fav_req;
   logic       oth_req;
   logic       pick_fav;
   assign fav_req  = tx_first ? tx_req : rx_req;                    // R5
   assign oth_req  = tx_first ? rx_req : tx_req;
   // Strict mode never looks at the ratio
   assign pick_fav = fav_req && (strict || !oth_req || credit_q <= {1'b0, ratio}); // R4 R6 R7
   assign rx_gnt   = tx_first ? (!pick_fav && oth_req) : pick_fav;
   assign tx_gnt   = tx_first ? pick_fav : (!pick_fav && oth_req);
   assign credit_d = !done ? credit_q :
                     (pick_fav && oth_req) ? credit_q + 3'd1 : 3'd0; // R3
   always_ff @(posedge clock)
   begin
      if (rst)
         credit_q <= 3'd0;
      else
         credit_q <= credit_d;
   end
endmodule : emdb_wrr
`default_nettype wire

// ### logic/emdb_dma_bus.sv
// Ethernet DMA bus control: APB registers, arbitration, burst and descriptor stepping, events
//
// Operation
// R1: Descriptor gap count ranges 0 to 31 words
// R2: Channel weight selectable from 1 to 4; the weight field is decoded but drives no logic
// R3: Ratio 1:1 to 4:1, direction swappable
// R4: Strict priority ignores the ratio
// R5: Transmit-first favours transmit, else receive
// R6: Strict mode: favoured channel always wins
// R7: Otherwise weighted round robin arbitration
// R8: Address align controls burst alignment
// R9: Extended descriptor layout when option set
// R10: Fixed or length-driven burst sizes
// R11: Burst limits 1,2,4,8,16,32 words; the burst register takes any six-bit limit 0 to 63 unchecked
// R12: Ring steps over gap words, wraps
// R13: Chained mode follows next pointer
// R14: Early receive after first buffer filled
// R15: Bus error disables DMA, raises event
// R16: Early transmit when frame in FIFO
// R17: Receive watchdog above 2048/10240 bytes
// R18: Host-owned receive descriptor suspends reception
// R19: Jabber above 2048/10240 stops transmit
// R20: Host-owned transmit descriptor suspends transmission
// R21: Underflow suspends transmit, raises event
// R22: Receive done after status write-back
// R23: Status bits sticky until cleared individually
`timescale 1ns/1ps
`default_nettype none
module emdb_dma_bus
(
   input  wire logic        clock,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Channel requests from the DMA engines
   input  wire logic        rx_bus_req,
   input  wire logic        tx_bus_req,
   input  wire logic        bus_done,
   output logic             rx_bus_gnt,
   output logic             tx_bus_gnt,
   // Burst planning for the granted channel
   input  wire logic [31:0] xfer_addr,
   input  wire logic [15:0] xfer_words_left,
   input  wire logic        xfer_first,
   output logic [5:0]       burst_words,
   output logic             burst_fixed,
   // Descriptor stepping
   input  wire logic        desc_step,
   input  wire logic [31:0] desc_cur,
   input  wire logic [31:0] desc_next_ptr,
   input  wire logic        desc_last,
   input  wire logic [31:0] ring_base,
   output logic [31:0]      desc_next,
   output logic             extended_descriptor_layout,
   // Engine events
   input  wire logic        rx_first_buf_full,
   input  wire logic        bus_fatal,
   input  wire logic        tx_frame_in_fifo,
   input  wire logic        rx_byte,
   input  wire logic        rx_frame_end,
   input  wire logic        rx_status_written,
   input  wire logic        rx_desc_host_owned,
   input  wire logic        tx_byte,
   input  wire logic        tx_frame_end,
   input  wire logic        tx_desc_host_owned,
   input  wire logic        tx_underflow,
   // Process state
   output logic             dma_enabled,
   output logic             rx_running,
   output logic             tx_running,
   output logic             tx_abort
);
   // ======================================================================
   // Registers
   logic [31:0]                      cfg_q;
   logic [31:0]                      burst_q;
   logic [emdb_pkg::NUM_EVENTS-1:0]  status_q;
   logic [emdb_pkg::NUM_EVENTS-1:0]  set_ev;
   logic                             en_q;
   logic                             rx_run_q;
   logic                             tx_run_q;
   logic                             abort_q;
   logic [13:0]                      rx_len_q;
   logic [13:0]                      tx_len_q;
   logic                             rx_wd_seen_q;
   logic [31:0]                      prdata_q;
   // ======================================================================
   // Bus decode; the slave answers in the first access cycle
   logic wr_acc;
   logic rd_acc;
   logic hit;
   assign hit     = paddr == emdb_pkg::CFG_ADDR || paddr == emdb_pkg::BURST_ADDR ||
                    paddr == emdb_pkg::STATUS_ADDR || paddr == emdb_pkg::CTRL_ADDR ||
                    paddr == emdb_pkg::STATE_ADDR;
   assign wr_acc  = psel && penable && pwrite && hit;
   assign rd_acc  = psel && !penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata  = prdata_q;
   logic wr_cfg;
   logic wr_burst;
   logic wr_stat;
   logic wr_ctrl;
   assign wr_cfg   = wr_acc && paddr == emdb_pkg::CFG_ADDR;
   assign wr_burst = wr_acc && paddr == emdb_pkg::BURST_ADDR;
   assign wr_stat  = wr_acc && paddr == emdb_pkg::STATUS_ADDR;
   assign wr_ctrl  = wr_acc && paddr == emdb_pkg::CTRL_ADDR;
   // ======================================================================
   // Configuration fields
   logic [1:0] weight;
   logic [1:0] ratio;
   logic       transmit_first_select;
   logic       strict_priority_select;
   logic       burst_address_align;
   logic       fixed_length_burst;
   logic       variable_burst_type;
   logic       chained_mode;
   logic       jumbo;
   logic [4:0] descriptor_gap_words;
   logic [5:0] receive_burst_limit;
   logic [5:0] transmit_burst_limit;
   assign weight                 = cfg_q[emdb_pkg::CFG_WEIGHT_LSB +: 2];  // R2
   assign ratio                  = cfg_q[emdb_pkg::CFG_RATIO_LSB +: 2];
   assign transmit_first_select  = cfg_q[emdb_pkg::CFG_TXFIRST];
   assign strict_priority_select = cfg_q[emdb_pkg::CFG_STRICT];
   assign burst_address_align    = cfg_q[emdb_pkg::CFG_ALIGN];
   assign fixed_length_burst     = cfg_q[emdb_pkg::CFG_FIXBURST];
   assign variable_burst_type    = cfg_q[emdb_pkg::CFG_VARBURST];
   assign extended_descriptor_layout = cfg_q[emdb_pkg::CFG_EXTDESC];  // R9
   assign chained_mode           = cfg_q[emdb_pkg::CFG_CHAINED];
   assign jumbo                  = cfg_q[emdb_pkg::CFG_JUMBO];
   assign descriptor_gap_words   = cfg_q[emdb_pkg::CFG_GAP_LSB +: 5];  // R1
   assign receive_burst_limit    = burst_q[emdb_pkg::BURST_RX_LSB +: 6];
   assign transmit_burst_limit   = burst_q[emdb_pkg::BURST_TX_LSB +: 6];
   // ======================================================================
   // Arbitration; no grants while the engine is disabled
   logic rx_gnt_raw;
   logic tx_gnt_raw;
   emdb_wrr u_wrr
   (
      .clock    (clock),
      .rst      (rst),
      .rx_req   (rx_bus_req && en_q && rx_run_q),
      .tx_req   (tx_bus_req && en_q && tx_run_q),
      .done     (bus_done),
      .ratio    (ratio),
      .tx_first (transmit_first_select),
      .strict   (strict_priority_select),
      .rx_gnt   (rx_gnt_raw),
      .tx_gnt   (tx_gnt_raw)
   );
   assign rx_bus_gnt = rx_gnt_raw;
   assign tx_bus_gnt = tx_gnt_raw;
   // ======================================================================
   // Burst planning: clip to limit, to remaining length, to alignment
   logic [5:0]  lim;
   logic [5:0]  lim_len;
   logic [5:0]  to_bound;
   logic [5:0]  left6;
   logic        need_align;
   assign lim        = tx_gnt_raw ? transmit_burst_limit : receive_burst_limit; // R11
   assign left6      = (xfer_words_left > 16'd32) ? 6'd32 : xfer_words_left[5:0];
   // Mixed bursts shrink to what is left; fixed bursts keep the full length
   assign lim_len    = (variable_burst_type && !fixed_length_burst && left6 < lim)
                       ? left6 : lim;                                      // R10
   assign need_align = burst_address_align && (fixed_length_burst || !xfer_first); // R8
   assign to_bound   = lim - (xfer_addr[7:2] & (lim - 6'd1));
   assign burst_fixed = fixed_length_burst;                                // R10
   always_ff @(posedge clock)
   begin
      if (rst)
         burst_words <= 6'd1;
      else
         burst_words <= (need_align && to_bound < lim_len) ? to_bound : lim_len;
   end
   // ======================================================================
   // Next descriptor address
   logic [31:0] desc_len;
   assign desc_len = 32'((extended_descriptor_layout ? emdb_pkg::DESC_EXT_WORDS
                          : emdb_pkg::DESC_BASE_WORDS) + descriptor_gap_words) << 2;
   always_ff @(posedge clock)
   begin
      if (rst)
         desc_next <= 32'h0000_0000;
      else if (desc_step)
         desc_next <= chained_mode ? desc_next_ptr :                       // R13
                      desc_last ? ring_base : desc_cur + desc_len;         // R12
   end
   // ======================================================================
   // Frame length watchdogs
   logic [13:0] max_len;
   logic        rx_over;
   logic        tx_over;
   assign max_len = jumbo ? 14'(emdb_pkg::LEN_JUMBO) : 14'(emdb_pkg::LEN_STD);
   assign rx_over = rx_byte && rx_len_q == max_len && !rx_wd_seen_q;       // R17
   assign tx_over = tx_byte && tx_len_q == max_len && tx_run_q;            // R19
   always_ff @(posedge clock)
   begin
      if (rst || rx_frame_end)
         rx_len_q <= 14'h0000;
      else if (rx_byte && rx_len_q != max_len)
         rx_len_q <= rx_len_q + 14'h0001;
   end
   always_ff @(posedge clock)
   begin
      if (rst || rx_frame_end)
         rx_wd_seen_q <= 1'b0;
      else if (rx_over)
         rx_wd_seen_q <= 1'b1;
   end
   always_ff @(posedge clock)
   begin
      if (rst || tx_frame_end)
         tx_len_q <= 14'h0000;
      else if (tx_byte && tx_len_q != max_len)
         tx_len_q <= tx_len_q + 14'h0001;
   end
   // ======================================================================
   // Event collection
   always_comb
   begin
      set_ev = '0;
      set_ev[emdb_pkg::ST_EARLY_RX] = rx_first_buf_full;                   // R14
      set_ev[emdb_pkg::ST_BUS_ERR]  = bus_fatal;                           // R15
      set_ev[emdb_pkg::ST_EARLY_TX] = tx_frame_in_fifo;                    // R16
      set_ev[emdb_pkg::ST_RX_WDOG]  = rx_over;                             // R17
      set_ev[emdb_pkg::ST_RX_NOBUF] = rx_desc_host_owned && rx_run_q;      // R18
      set_ev[emdb_pkg::ST_RX_DONE]  = rx_status_written;                   // R22
      set_ev[emdb_pkg::ST_TX_UFLOW] = tx_underflow && tx_run_q;            // R21
      set_ev[emdb_pkg::ST_TX_JAB]   = tx_over;                             // R19
      set_ev[emdb_pkg::ST_TX_NOBUF] = tx_desc_host_owned && tx_run_q;      // R20
      set_ev[emdb_pkg::ST_TX_STOP]  = tx_over;                             // R19
   end
   // Sticky status, write one to clear, a new event beats the clear
   always_ff @(posedge clock)
   begin
      if (rst)
         status_q <= '0;
      else
         status_q <= set_ev | (status_q & ~({emdb_pkg::NUM_EVENTS{wr_stat}}
                     & pwdata[emdb_pkg::NUM_EVENTS-1:0]));                 // R23
   end
   // ======================================================================
   // Configuration registers
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cfg_q   <= emdb_pkg::CFG_RESET;
         burst_q <= emdb_pkg::BURST_RESET;
      end
      else
      begin
         if (wr_cfg)
            cfg_q <= pwdata & 32'h001f_0fff;
         if (wr_burst)
            burst_q <= pwdata & 32'h0000_3f3f;
      end
   end
   // ======================================================================
   // Engine enable; a fatal bus error wins, and one write may enable and poll at once
   logic en_next;
   assign en_next = !bus_fatal && (wr_ctrl ? pwdata[emdb_pkg::CTRL_ENABLE] : en_q);
   always_ff @(posedge clock)
   begin
      if (rst || bus_fatal)                                                // R15
         en_q <= 1'b0;
      else if (wr_ctrl)
         en_q <= pwdata[emdb_pkg::CTRL_ENABLE];
   end
   // Receive process: suspends on a host-owned descriptor, poll resumes
   always_ff @(posedge clock)
   begin
      if (rst || !en_next)
         rx_run_q <= 1'b0;
      else if (rx_desc_host_owned)                                         // R18
         rx_run_q <= 1'b0;
      else if (wr_ctrl && pwdata[emdb_pkg::CTRL_RX_POLL])
         rx_run_q <= 1'b1;
   end
   // Transmit process: stops on jabber, suspends on underflow or host-owned descriptor
   always_ff @(posedge clock)
   begin
      if (rst || !en_next)
         tx_run_q <= 1'b0;
      else if (tx_over || tx_underflow || tx_desc_host_owned)              // R19 R20 R21
         tx_run_q <= 1'b0;
      else if (wr_ctrl && pwdata[emdb_pkg::CTRL_TX_POLL])
         tx_run_q <= 1'b1;
   end
   always_ff @(posedge clock)
   begin
      if (rst)
         abort_q <= 1'b0;
      else
         abort_q <= tx_over;                                               // R19
   end
   assign dma_enabled = en_q;
   assign rx_running  = rx_run_q;
   assign tx_running  = tx_run_q;
   assign tx_abort    = abort_q;
   // ======================================================================
   // Read data captured in setup so it stands through the access cycle
   logic [31:0] rd_mux;
   assign rd_mux = (paddr == emdb_pkg::CFG_ADDR)    ? cfg_q :
                   (paddr == emdb_pkg::BURST_ADDR)  ? burst_q :
                   (paddr == emdb_pkg::STATUS_ADDR) ? 32'(status_q) :
                   (paddr == emdb_pkg::CTRL_ADDR)   ? {31'h0, en_q} :
                   (paddr == emdb_pkg::STATE_ADDR)  ? {28'h0, abort_q, tx_run_q,
                                                       rx_run_q, en_q} :
                   32'h0000_0000;
   always_ff @(posedge clock)
   begin
      if (rst)
         prdata_q <= 32'h0000_0000;
      else if (rd_acc)
         prdata_q <= rd_mux;
   end
   // ======================================================================
   // Checks
   property p_bus_err_disables;
      @(posedge clock) disable iff (rst) bus_fatal |=> !en_q && status_q[emdb_pkg::ST_BUS_ERR];
   endproperty
   a_bus_err_disables: assert property (p_bus_err_disables) else $error("bus error not handled"); // R15
   property p_sticky;
      @(posedge clock) disable iff (rst) status_q[emdb_pkg::ST_RX_DONE] && !wr_stat
         |=> status_q[emdb_pkg::ST_RX_DONE];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status bit lost"); // R23
   property p_set_wins;
      @(posedge clock) disable iff (rst) set_ev[emdb_pkg::ST_EARLY_RX] |=> status_q[emdb_pkg::ST_EARLY_RX];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("early receive lost"); // R14
   property p_strict_fav;
      @(posedge clock) disable iff (rst) strict_priority_select && !transmit_first_select
         && rx_bus_req && en_q && rx_run_q |-> rx_bus_gnt && !tx_bus_gnt;
   endproperty
   a_strict_fav: assert property (p_strict_fav) else $error("strict receive not favoured"); // R6
   property p_one_grant;
      @(posedge clock) disable iff (rst) !(rx_bus_gnt && tx_bus_gnt);
   endproperty
   a_one_grant: assert property (p_one_grant) else $error("two grants"); // R7
   property p_jabber_stop;
      @(posedge clock) disable iff (rst) tx_over |=> !tx_run_q && tx_abort && status_q[emdb_pkg::ST_TX_JAB];
   endproperty
   a_jabber_stop: assert property (p_jabber_stop) else $error("jabber not handled"); // R19
   property p_rx_suspend;
      @(posedge clock) disable iff (rst) rx_desc_host_owned && rx_run_q
         |=> !rx_run_q && status_q[emdb_pkg::ST_RX_NOBUF];
   endproperty
   a_rx_suspend: assert property (p_rx_suspend) else $error("receive not suspended"); // R18
   property p_uflow;
      @(posedge clock) disable iff (rst) tx_underflow && tx_run_q
         |=> !tx_run_q && status_q[emdb_pkg::ST_TX_UFLOW];
   endproperty
   a_uflow: assert property (p_uflow) else $error("underflow not handled"); // R21
   property p_burst_limit;
      @(posedge clock) disable iff (rst) ##1 burst_words <= $past(lim);
   endproperty
   a_burst_limit: assert property (p_burst_limit) else $error("burst over limit"); // R11
endmodule : emdb_dma_bus
`default_nettype wire

// ### verif/emdb_bus_model.sv
// Behavioural system bus on the far side: ends each granted transfer
`timescale 1ns/1ps
`default_nettype none
module emdb_bus_model
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic gnt,
   input  wire logic slow,
   output logic      done
);
   logic [1:0] cnt_q;
   // ==========================================================
   // Transfer timing
   // Slow mode raises done four cycles after the grant, so each transfer lasts five cycles, as a busy memory would
   always_ff @(posedge clock)
   begin
      if (rst || !gnt || done)
      begin
         cnt_q <= 2'h0;
         done  <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_q + 2'h1;
         done  <= slow ? (cnt_q == 2'h3) : 1'b1;
      end
   end
endmodule : emdb_bus_model
`default_nettype wire

// ### verif/emdb_dma_bus_tb.sv
// Self-checking bench of the DMA bus control block
`timescale 1ns/1ps
`default_nettype none
module emdb_dma_bus_tb;
   localparam logic [7:0] CF = emdb_pkg::CFG_ADDR;
   localparam logic [7:0] ST = emdb_pkg::STATUS_ADDR;
   localparam logic [7:0] CT = emdb_pkg::CTRL_ADDR;
   logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, dcur = 32'h1000, dptr = 32'h0, dnext, xa = 32'h0;
   logic [15:0] xl = 16'h0040;
   logic        pready, pslverr, rxq = 1'b0, txq = 1'b0, done, rg, tg, bf, ext;
   logic        dstep = 1'b0, dlast = 1'b0, slow = 1'b0, en, rxr, txr, abrt, xf = 1'b0;
   logic [5:0]  bw;
   logic [10:0] ev = 11'h0;
   logic [31:0] expq[$], mq[$];
   logic        seq[$];
   int          errors = 0, checks_done = 0, cycles = 0, seed = 41, g;
   always #2 clock = ~clock;
   // ==========================================================
   // Block and far-side model
   emdb_dma_bus i_emdb_dma_bus
   (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_bus_req(rxq), .tx_bus_req(txq), .bus_done(done), .rx_bus_gnt(rg), .tx_bus_gnt(tg),
      .xfer_addr(xa), .xfer_words_left(xl), .xfer_first(xf),
      .burst_words(bw), .burst_fixed(bf), .desc_step(dstep), .desc_cur(dcur),
      .desc_next_ptr(dptr), .desc_last(dlast), .ring_base(32'h8000), .desc_next(dnext),
      .extended_descriptor_layout(ext), .rx_first_buf_full(ev[0]), .bus_fatal(ev[1]),
      .tx_frame_in_fifo(ev[2]), .rx_byte(ev[3]), .rx_frame_end(ev[4]),
      .rx_status_written(ev[5]), .rx_desc_host_owned(ev[6]), .tx_byte(ev[7]),
      .tx_frame_end(ev[8]), .tx_desc_host_owned(ev[9]), .tx_underflow(ev[10]),
      .dma_enabled(en), .rx_running(rxr), .tx_running(txr), .tx_abort(abrt)
   );
   emdb_bus_model i_emdb_bus_model
   (
      .clock(clock), .rst(rst), .gnt(rg | tg), .slow(slow), .done(done)
   );
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   // APB master: request held until pready is seen high
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
      @(posedge clock);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      expq.push_back(e);
      mq.push_back(m);
      wr(a, 32'h0, 1'b0);
   endtask : rd
   task automatic pulse(input logic [10:0] m, input int n);
      @(posedge clock);
      ev <= m;
      repeat (n) @(posedge clock);
      ev <= 11'h0;
   endtask : pulse
   task automatic st(input logic [2:0] e);
      @(posedge clock);
      check({en, rxr, txr}, e);
   endtask : st
   task automatic desc(input logic [31:0] cfg, input logic last, input logic [31:0] e);
      wr(CF, cfg);
      @(posedge clock);
      dlast <= last;
      dstep <= 1'b1;
      @(posedge clock);
      dstep <= 1'b0;
      @(posedge clock);
      check(dnext, e);
   endtask : desc
   // Burst size for one transfer position; result registered one edge later
   task automatic bsize(input logic [31:0] cfg, input logic [31:0] a, input logic [15:0] l,
                        input logic f, input logic [5:0] e);
      wr(CF, cfg);
      xa <= a;
      xl <= l;
      xf <= f;
      repeat (2) @(posedge clock);
      check(bw, e);
   endtask : bsize
   // Both channels ask; grant order is read from the log of finished transfers
   task automatic arb(input logic [31:0] cfg);
      int i;
      wr(CF, cfg);
      seq.delete();
      @(posedge clock);
      slow <= 1'($random(seed));
      rxq  <= 1'b1;
      txq  <= 1'b1;
      while (seq.size() < 14) @(posedge clock);
      rxq <= 1'b0;
      txq <= 1'b0;
      i = 0;
      while (i < 8 && seq[i] == cfg[4]) i++;
      if (cfg[5]) check(i, 8);
      else for (int k = 1; k <= cfg[3:2] + 2; k++) check(seq[i+k], (k <= cfg[3:2] + 1) == cfg[4]);
   endtask : arb
   // Read results are compared as they appear on the bus
   always @(posedge clock)
   begin
      if (psel && penable && pready && !pwrite)
         check(prdata & mq.pop_front(), expq.pop_front());
      if (psel && penable && pready)
         check(pslverr, paddr == 8'h14);
      if (done)
         seq.push_back(tg);
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         finish_test();
      end
   end
   initial
   begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      rd(CF, emdb_pkg::CFG_RESET);
      rd(emdb_pkg::BURST_ADDR, emdb_pkg::BURST_RESET);
      rd(8'h14, 32'h0);
      wr(CT, 32'h7);
      st(3'b111);
      pulse(11'h005, 1);
      rd(ST, 32'h5);
      wr(ST, 32'h1);
      rd(ST, 32'h4);
      wr(ST, 32'h3ff);
      pulse(11'h400, 1);
      st(3'b110);
      rd(ST, 32'h40, 32'h1ff);
      wr(ST, 32'h3ff);
      wr(CT, 32'h5);
      pulse(11'h240, 1);
      st(3'b100);
      rd(ST, 32'h110);
      wr(ST, 32'h3ff);
      wr(CT, 32'h7);
      st(3'b111);
      pulse(11'h010, 1);
      rd(ST, 32'h0);
      pulse(11'h020, 1);
      rd(ST, 32'h20);
      wr(ST, 32'h3ff);
      pulse(11'h088, 2048);
      rd(ST, 32'h0, 32'h1ff);
      pulse(11'h088, 1);
      st(3'b110);
      check(abrt, 1'b1);
      rd(ST, 32'h288);
      pulse(11'h002, 1);
      @(posedge clock);
      check(en, 1'b0);
      rd(ST, 32'h2, 32'h2);
      wr(ST, 32'h3ff);
      wr(CT, 32'h7);
      wr(CF, 32'h800);
      pulse(11'h010, 1);
      pulse(11'h008, 10240);
      rd(ST, 32'h0, 32'h8);
      pulse(11'h008, 1);
      rd(ST, 32'h8, 32'h8);
      for (int r = 0; r < 4; r++)
         for (int t = 0; t < 2; t++)
            arb((r << 2) | (t << 4));
      arb(32'h2c);
      arb(32'h3c);
      g = $random(seed) & 31;
      dptr <= $random(seed);
      desc((g << 16) | 3, 1'b0, 32'h1000 + 4 * (4 + g));
      rd(CF, (g << 16) | 3);
      desc((g << 16) | 32'h200, 1'b0, 32'h1000 + 4 * (8 + g));
      check(ext, 1'b1);
      desc(32'h0, 1'b1, 32'h8000);
      desc(32'h400, 1'b0, dptr);
      wr(CF, 32'h80);
      wr(emdb_pkg::BURST_ADDR, 32'h0808);
      rxq <= 1'b1;
      repeat (3) @(posedge clock);
      check(bw, 6'h08);
      check(bf, 1'b1);
      bsize(32'h140, 32'h18, 16'h5, 1'b0, 6'd2);
      bsize(32'h140, 32'h18, 16'h5, 1'b1, 6'd5);
      bsize(32'hc0, 32'h18, 16'h5, 1'b1, 6'd2);
      finish_test();
   end
endmodule : emdb_dma_bus_tb
`default_nettype wire
